/* File: afe_config_pkg.sv */
/*
 Constants of the configuration register bank: map, reset values,
 fixed-bit layout, command byte encodings and field positions.
 Assumes a single clock domain; no other files are needed.
*/
package afe_config_pkg;

   localparam int NUM_REGS = 12;

   localparam logic [4:0] ADDR_PART_ID = 5'h00;
   localparam logic [4:0] ADDR_RATE_CFG = 5'h01;
   localparam logic [4:0] ADDR_REF_TEST_CFG = 5'h02;
   localparam logic [4:0] ADDR_DETACH_STATUS = 5'h08;

   // Entry 11 first, entry 0 last
   localparam logic [11:0][7:0] RESET_VALUE = {
      8'h0C, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h10, 8'h80, 8'h02, 8'h00};
   localparam logic [11:0][7:0] FIXED_MASK = {
      8'hF0, 8'h79, 8'h02, 8'hA0, 8'hC0, 8'h00,
      8'h00, 8'h00, 8'h12, 8'h84, 8'h78, 8'hFF};
   localparam logic [11:0][7:0] FIXED_VALUE = {
      8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h10, 8'h80, 8'h00, 8'h00};

   // Identification layout
   localparam logic [7:0] PART_ID_FIXED_ONE = 8'h10;
   localparam int PART_FAMILY_LSB = 5;

   // Conversion and rate fields
   localparam int SINGLE_SHOT_BIT = 7;
   localparam int RATE_SELECT_MSB = 2;
   localparam logic [2:0] RATE_CODE_LIMIT = 3'h6;
   localparam logic [10:0] OSR_BASE = 11'h400;

   // Status bits driven by hardware in the detach status register
   localparam logic [7:0] DETACH_HW_MASK = 8'h1F;

   // Command byte prefixes
   localparam logic [2:0] REGISTER_READ_CMD = 3'h1;
   localparam logic [2:0] REGISTER_WRITE_CMD = 3'h2;

   typedef enum logic [1:0] {
      CMD_IDLE = 2'b00,
      CMD_READ = 2'b01,
      CMD_WRITE = 2'b10,
      CMD_IGNORE = 2'b11
   } cmd_kind_e;

endpackage

/* File: afe_config_register_bank.sv */
/*
 Serial command engine and register bank top. Decodes register read
 and write commands and the continuous-readout start and stop bytes.
 Assumes cs_n, sclk and din are synchronous to core_clk and that sclk
 toggles no faster than one level per two core_clk cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module afe_config_register_bank
   import afe_config_pkg::*;
#(
   parameter logic [7:0] START_CONTINUOUS_OPCODE = 8'h10,
   parameter logic [7:0] STOP_CONTINUOUS_OPCODE = 8'h11,
   parameter logic [2:0] PART_FAMILY_CODE = 3'h7, // Arbitrary value
   parameter logic [1:0] PART_VARIANT_CODE = 2'h0 // Arbitrary value
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   input wire logic [4:0] detach_flags,
   output logic dout,
   output logic dout_oe,
   output logic continuous_readout,
   output logic single_shot,
   output logic [2:0] rate_select,
   output logic [10:0] oversampling_ratio,
   output logic [11:0][7:0] config_image
);

   if (START_CONTINUOUS_OPCODE == STOP_CONTINUOUS_OPCODE) begin : g_bad_op
      $error("afe_config_register_bank: start and stop opcodes clash");
   end

   ////////////////////////////////////////////////////////////////////////
   // Engine state

   typedef struct packed {
      logic sclk_d;
      logic [2:0] bit_cnt;
      logic [1:0] byte_cnt;
      cmd_kind_e kind;
      logic [4:0] addr;
      logic [4:0] remaining;
      logic cont;
      logic [7:0] in_sh;
      logic [7:0] out_sh;
      logic dout;
      logic dout_oe;
      logic wr_en;
      logic [4:0] wr_addr;
      logic [7:0] wr_data;
      logic single_shot;
      logic [2:0] rate;
      logic [10:0] osr;
   } engine_s;

   // Power-up state: continuous readout, register access locked
   localparam engine_s ENGINE_RESET = '{
      sclk_d: 1'b0,
      bit_cnt: 3'h0,
      byte_cnt: 2'h0,
      kind: CMD_IDLE,
      addr: 5'h00,
      remaining: 5'h00,
      cont: 1'b1,
      in_sh: 8'h00,
      out_sh: 8'h00,
      dout: 1'b0,
      dout_oe: 1'b0,
      wr_en: 1'b0,
      wr_addr: 5'h00,
      wr_data: 8'h00,
      single_shot: RESET_VALUE[ADDR_RATE_CFG][SINGLE_SHOT_BIT],
      rate: RESET_VALUE[ADDR_RATE_CFG][RATE_SELECT_MSB:0],
      osr: OSR_BASE >> RESET_VALUE[ADDR_RATE_CFG][RATE_SELECT_MSB:0]
   };

   ////////////////////////////////////////////////////////////////////////
   // Register store

   reg_access_if acc ();

   engine_s state_r;
   engine_s state_nxt;
   logic [11:0][7:0] image;
   logic sclk_rise;
   logic sclk_fall;
   logic [7:0] byte_in;

   afe_register_store #(
      .REG_COUNT(NUM_REGS),
      .PART_FAMILY_CODE(PART_FAMILY_CODE),
      .PART_VARIANT_CODE(PART_VARIANT_CODE)
   ) u_store (
      .core_clk(core_clk),
      .reset(reset),
      .clk_en(clk_en),
      .acc(acc.bank),
      .config_image(image)
   );

   assign acc.wr_en = state_r.wr_en;
   assign acc.wr_addr = state_r.wr_addr;
   assign acc.wr_data = state_r.wr_data;
   assign acc.rd_addr = state_r.addr;
   assign acc.detach_flags = detach_flags;

   ////////////////////////////////////////////////////////////////////////
   // Serial clock edges

   assign sclk_rise = sclk && !state_r.sclk_d;
   assign sclk_fall = !sclk && state_r.sclk_d;
   assign byte_in = {state_r.in_sh[6:0], din};

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_nxt = state_r;
      state_nxt.sclk_d = sclk;
      state_nxt.wr_en = 1'b0;
      // Decoded configuration, one cycle behind the store
      state_nxt.single_shot = image[ADDR_RATE_CFG][SINGLE_SHOT_BIT];
      state_nxt.rate = image[ADDR_RATE_CFG][RATE_SELECT_MSB:0];
      if (state_nxt.rate > RATE_CODE_LIMIT) begin
         state_nxt.osr = 11'h000;
      end else begin
         state_nxt.osr = OSR_BASE >> state_nxt.rate;
      end
      if (cs_n) begin
         state_nxt.bit_cnt = 3'h0;
         state_nxt.byte_cnt = 2'h0;
         state_nxt.kind = CMD_IDLE;
         state_nxt.dout_oe = 1'b0;
         state_nxt.dout = 1'b0;
      end else begin
         state_nxt.dout_oe = 1'b1;
         if (sclk_rise) begin
            if (state_r.kind == CMD_READ && state_r.byte_cnt == 2'h2
                && state_r.bit_cnt == 3'h0) begin
               // First data bit of each byte on rise 17, 25, ...
               state_nxt.dout = acc.rd_data[7];
               state_nxt.out_sh = {acc.rd_data[6:0], 1'b0};
            end else begin
               state_nxt.dout = state_r.out_sh[7];
               state_nxt.out_sh = {state_r.out_sh[6:0], 1'b0};
            end
         end
         if (sclk_fall) begin
            state_nxt.in_sh = byte_in;
            state_nxt.bit_cnt = state_r.bit_cnt + 3'h1;
            if (state_r.bit_cnt == 3'h7) begin
               if (state_r.byte_cnt != 2'h2) begin
                  state_nxt.byte_cnt = state_r.byte_cnt + 2'h1;
               end
               case (state_r.byte_cnt)
                  2'h0: begin
                     state_nxt.addr = byte_in[4:0];
                     state_nxt.kind = CMD_IGNORE;
                     if (byte_in == STOP_CONTINUOUS_OPCODE) begin
                        state_nxt.cont = 1'b0;
                     end else if (byte_in == START_CONTINUOUS_OPCODE) begin
                        state_nxt.cont = 1'b1;
                     end else if (!state_r.cont) begin
                        case (byte_in[7:5])
                           REGISTER_READ_CMD: begin
                              state_nxt.kind = CMD_READ;
                           end
                           REGISTER_WRITE_CMD: begin
                              state_nxt.kind = CMD_WRITE;
                           end
                           default: begin
                              state_nxt.kind = CMD_IGNORE;
                           end
                        endcase
                     end
                  end
                  2'h1: begin
                     state_nxt.remaining = byte_in[4:0];
                  end
                  default: begin
                     if (state_r.kind == CMD_WRITE) begin
                        state_nxt.wr_en = 1'b1;
                        state_nxt.wr_addr = state_r.addr;
                        state_nxt.wr_data = byte_in;
                     end
                     state_nxt.addr = state_r.addr + 5'h01;
                     if (state_r.remaining == 5'h00) begin
                        state_nxt.kind = CMD_IGNORE;
                     end else begin
                        state_nxt.remaining = state_r.remaining - 5'h01;
                     end
                  end
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r <= ENGINE_RESET;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign dout = state_r.dout;
   assign dout_oe = state_r.dout_oe;
   assign continuous_readout = state_r.cont;
   assign single_shot = state_r.single_shot;
   assign rate_select = state_r.rate;
   assign oversampling_ratio = state_r.osr;
   assign config_image = image;

endmodule
`default_nettype wire

/* File: afe_config_register_bank_monitor.sv */
/*
 Assertion checker for the configuration register bank top.
 Assumes it is bound to afe_config_register_bank on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
module afe_config_register_bank_monitor (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic cs_n,
   input wire logic dout_oe,
   input wire logic continuous_readout,
   input wire logic single_shot,
   input wire logic [2:0] rate_select,
   input wire logic [10:0] oversampling_ratio,
   input wire logic [11:0][7:0] config_image
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   AST_ID_STABLE: assert property ($stable(config_image[0]))
      else $error("identification register changed");
   AST_ID_FIXED: assert property (config_image[0][4:2] == 3'h4)
      else $error("identification fixed bits wrong");
   AST_CFG1_ZERO: assert property (config_image[1][6:3] == 4'h0)
      else $error("rate config bits 6..3 not zero");
   AST_CFG2_FIXED: assert property ({config_image[2][7],
      config_image[2][2]} == 2'b10) else $error("ref config fixed bits");
   AST_SINGLE: assert property (clk_en |->
      single_shot == $past(config_image[1][7]))
      else $error("single shot does not follow register");
   AST_RATE: assert property (clk_en |->
      rate_select == $past(config_image[1][2:0]))
      else $error("rate select does not follow register");
   AST_OSR: assert property (oversampling_ratio ==
      ((rate_select == 3'h7) ? 11'h000 : (11'h400 >> rate_select)))
      else $error("oversampling ratio mismatch");
   AST_OE: assert property (clk_en |-> dout_oe == !$past(cs_n))
      else $error("output enable not tracking select");
   AST_RESET: assert property ($fell(reset) |->
      continuous_readout && rate_select == 3'h2)
      else $error("wrong state after reset");
   COV_SINGLE: cover property ($rose(single_shot));
   COV_STOP: cover property ($fell(continuous_readout));
   COV_FAST: cover property (rate_select == 3'h6);
endmodule
bind afe_config_register_bank afe_config_register_bank_monitor i_mon (
   .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .cs_n(cs_n),
   .dout_oe(dout_oe), .continuous_readout(continuous_readout),
   .single_shot(single_shot), .rate_select(rate_select),
   .oversampling_ratio(oversampling_ratio), .config_image(config_image));
`default_nettype wire

/* File: afe_register_store.sv */
/*
 Register store: twelve byte registers with reset values and fixed
 bits, a read-only identification entry and live detach flags.
 Assumes writes arrive as single-cycle strobes from the serial engine.
*/
`timescale 1ns/10ps
`default_nettype none
module afe_register_store
   import afe_config_pkg::*;
#(
   parameter int REG_COUNT = NUM_REGS,
   parameter logic [2:0] PART_FAMILY_CODE = 3'h7, // Arbitrary value
   parameter logic [1:0] PART_VARIANT_CODE = 2'h0 // Arbitrary value
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clk_en,
   reg_access_if.bank acc,
   output logic [11:0][7:0] config_image
);

   if (REG_COUNT != NUM_REGS) begin : g_bad_count
      $error("afe_register_store: REG_COUNT must equal the map size");
   end

   typedef struct packed {
      logic [11:0][7:0] regs;
   } store_s;

   localparam logic [7:0] PART_ID_VALUE = 8'({PART_FAMILY_CODE, 3'h0,
      PART_VARIANT_CODE}) | PART_ID_FIXED_ONE;
   // Fixed bits set at reset, so the image reads the flops directly
   localparam logic [11:0][7:0] RESET_IMAGE = {
      (RESET_VALUE[11:1] & ~FIXED_MASK[11:1]) | FIXED_VALUE[11:1],
      PART_ID_VALUE};

   store_s state_r;
   store_s state_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Read port

   always_comb begin
      if (acc.rd_addr < 5'(NUM_REGS)) begin
         acc.rd_data = state_r.regs[acc.rd_addr[3:0]];
      end else begin
         acc.rd_data = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      state_nxt = state_r;
      if (acc.wr_en && acc.wr_addr != ADDR_PART_ID
          && acc.wr_addr < 5'(NUM_REGS)) begin
         state_nxt.regs[acc.wr_addr[3:0]] = (acc.wr_data
            & ~FIXED_MASK[acc.wr_addr[3:0]])
            | FIXED_VALUE[acc.wr_addr[3:0]];
      end
      // Detach flags follow the hardware, not the host
      state_nxt.regs[ADDR_DETACH_STATUS[3:0]] =
         (state_nxt.regs[ADDR_DETACH_STATUS[3:0]] & ~DETACH_HW_MASK)
         | {3'h0, acc.detach_flags};
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_r.regs <= RESET_IMAGE;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   assign config_image = state_r.regs;

endmodule
`default_nettype wire

/* File: host_serial_model.sv */
/*
 Host side of the serial command port: frames and byte transfers.
 Assumes sclk levels of three core_clk cycles suit the engine.
*/
`timescale 1ns/10ps
`default_nettype none
module host_serial_model (
   input wire logic core_clk,
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire logic dout
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      din = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic frame_start;
      wait_clk(1);
      cs_n = 1'b0;
      wait_clk(3);
   endtask
   // Released data line shows the inverse of its last level
   task automatic frame_end;
      wait_clk(2);
      cs_n = 1'b1;
      din = ~din;
      wait_clk(3);
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         din = tx[i];
         sclk = 1'b1;
         wait_clk(3);
         rx[i] = dout;
         sclk = 1'b0;
         wait_clk(3);
      end
   endtask
endmodule
`default_nettype wire

/* File: reg_access_if.sv */
/*
 Carrier between the serial engine and the register store.
 Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface reg_access_if;
   logic wr_en;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   logic [4:0] rd_addr;
   logic [7:0] rd_data;
   logic [4:0] detach_flags;

   modport engine (
      output wr_en, wr_addr, wr_data, rd_addr, detach_flags,
      input rd_data
   );
   modport bank (
      input wr_en, wr_addr, wr_data, rd_addr, detach_flags,
      output rd_data
   );
endinterface
`default_nettype wire

/* File: tb.sv */
/*
 Self-checking bench of the configuration register bank.
 Assumes the host model drives the serial port of the design.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   import afe_config_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
   logic cs_n, sclk, din, dout, dout_oe, cont, single;
   logic [4:0] detach_flags = 5'h15;
   logic [2:0] rate;
   logic [10:0] osr;
   logic [11:0][7:0] img;
   logic [7:0] r, d;
   int miscompares = 0, total_checks = 0;
   always #2.5 core_clk = ~core_clk;
   host_serial_model i_host_serial_model (.core_clk(core_clk),
      .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
   afe_config_register_bank i_afe_config_register_bank (
      .core_clk(core_clk), .reset(reset), .clk_en(clk_en), .cs_n(cs_n),
      .sclk(sclk), .din(din), .detach_flags(detach_flags), .dout(dout),
      .dout_oe(dout_oe), .continuous_readout(cont), .single_shot(single),
      .rate_select(rate), .oversampling_ratio(osr), .config_image(img));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [10:0] e, g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      i_host_serial_model.frame_start;
      i_host_serial_model.xfer({REGISTER_WRITE_CMD, a}, r);
      i_host_serial_model.xfer(8'h00, r);
      i_host_serial_model.xfer(v, r);
      i_host_serial_model.frame_end;
   endtask
   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      i_host_serial_model.frame_start;
      i_host_serial_model.xfer({REGISTER_READ_CMD, a}, r);
      i_host_serial_model.xfer(8'h00, r);
      i_host_serial_model.xfer(8'h00, v);
      i_host_serial_model.frame_end;
   endtask
   task automatic t_reset;
      chk("cont", 1, cont);
      chk("rate", 2, rate);
      chk("osr", 11'h100, osr);
      chk("id", 8'hF0, img[0]);
      chk("cfg1", 8'h02, img[1]);
      chk("cfg2", 8'h80, img[2]);
   endtask
   task automatic t_blocked;
      rd(1, d);
      chk("blocked read", 0, d);
      wr(1, 8'h86);
      chk("blocked write", 8'h02, img[1]);
      i_host_serial_model.frame_start;
      i_host_serial_model.xfer(8'h11, r);
      i_host_serial_model.frame_end;
      for (int i = 0; i < 50 && cont !== 1'b0; i++) begin
         i_host_serial_model.wait_clk(1);
      end
      chk("cont after stop", 0, cont);
      if (cont !== 1'b0) begin
         stop_test;
      end
   endtask
   task automatic t_id;
      rd(0, d);
      chk("id read", 8'hF0, d);
      wr(0, 8'h00);
      rd(0, d);
      chk("id after write", 8'hF0, d);
   endtask
   task automatic t_rates;
      for (int c = 0; c < 7; c++) begin
         wr(1, 8'(c));
         chk("rate", 11'(c), rate);
         chk("osr", 11'h400 >> c, osr);
         rd(1, d);
         chk("cfg1 read", 11'(c), d);
      end
      wr(1, 8'h86);
      chk("cfg1 single", 8'h86, img[1]);
      chk("single", 1, single);
      chk("osr code6", 11'h010, osr);
      wr(1, 8'h02);
      chk("single off", 0, single);
   endtask
   task automatic t_multi;
      i_host_serial_model.frame_start;
      i_host_serial_model.xfer({REGISTER_WRITE_CMD, 5'h01}, r);
      i_host_serial_model.xfer(8'h02, r);
      i_host_serial_model.xfer(8'h83, r);
      i_host_serial_model.xfer(8'hFB, r);
      i_host_serial_model.xfer(8'hFF, r);
      i_host_serial_model.frame_end;
      i_host_serial_model.frame_start;
      i_host_serial_model.xfer({REGISTER_READ_CMD, 5'h01}, r);
      i_host_serial_model.xfer(8'h02, r);
      i_host_serial_model.xfer(8'h00, d);
      chk("multi cfg1", 8'h83, d);
      i_host_serial_model.xfer(8'h00, d);
      chk("multi cfg2", 8'hFB, d);
      i_host_serial_model.xfer(8'h00, d);
      chk("multi reg3 fixed", 8'hFD, d);
      i_host_serial_model.frame_end;
   endtask
   task automatic t_freeze;
      chk("detach", 8'h15, img[8]);
      clk_en = 1'b0;
      detach_flags = 5'h0A;
      i_host_serial_model.wait_clk(4);
      chk("frozen detach", 8'h15, img[8]);
      clk_en = 1'b1;
      i_host_serial_model.wait_clk(2);
      chk("detach", 8'h0A, img[8]);
   endtask
   task automatic t_rerun;
      reset = 1'b1;
      i_host_serial_model.wait_clk(8);
      reset = 1'b0;
      i_host_serial_model.wait_clk(2);
      t_reset;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      #1 reset = 1'b0;
      i_host_serial_model.wait_clk(2);
      t_reset;
      t_freeze;
      t_blocked;
      t_id;
      t_rates;
      t_multi;
      t_rerun;
      stop_test;
   end
endmodule
`default_nettype wire
